// [verilog/rscl_top.sv]
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module rscl_top (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Strap pins, asynchronous to the clock.
	input wire logic mgmt_addr_strap_bit0_i,
	input wire logic mgmt_addr_strap_bit1_i,
	input wire logic mgmt_addr_strap_bit2_i,
	input wire logic [2:0] if_mode_strap_i,
	input wire logic isolate_strap_i,
	input wire logic autoneg_enable_strap_i,
	input wire logic speed_strap_i,
	input wire logic duplex_strap_i,
	input wire logic broadcast_off_strap_i,
	input wire logic wake_output_enable_strap_i,
	input wire logic gate_test_strap_n_i,
	// Same-clock management address probe and wake request.
	input wire logic [4:0] mgmt_req_addr_i,
	input wire logic wake_req_i,
	// Classic Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [rscl_pkg::WB_AW-1:0] wb_adr_i,
	input wire logic [rscl_pkg::WB_SW-1:0] wb_sel_i,
	input wire logic [rscl_pkg::WB_DW-1:0] wb_dat_i,
	output logic [rscl_pkg::WB_DW-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Applied configuration.
	output logic [4:0] mgmt_addr_o,
	output logic [2:0] if_mode_o,
	output logic mode_reserved_o,
	output logic isolate_o,
	output logic autoneg_en_o,
	output logic speed_100_o,
	output logic half_duplex_o,
	output logic bcast_off_o,
	output logic wake_out_en_o,
	output logic gate_test_en_o,
	output logic config_valid_o,
	output logic addr_match_o,
	output logic addr_bcast_o,
	output logic wake_event_output_o
);
	import rscl_pkg::*;

	// Merges a write word into a 16-bit register under byte enables.
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		merge16 = old;
		if (sel[0]) begin
			merge16[7:0] = wd[7:0];
		end
		if (sel[1]) begin
			merge16[15:8] = wd[15:8];
		end
	endfunction

	// Management address that a strap vector gives; the top bits are fixed.
	function automatic logic [4:0] strap_addr(input logic [STRAP_W-1:0] s);
		strap_addr = {ADDR_UPPER, s[SB_ADDR0 +: 3]};
	endfunction

	// Raw strap vector in the package layout.
	logic [STRAP_W-1:0] strap_pins;
	// Three-stage synchroniser and agreement filter.
	logic [STRAP_W-1:0] sync1_reg;
	logic [STRAP_W-1:0] sync2_reg;
	logic [STRAP_W-1:0] sync3_reg;
	logic [STRAP_W-1:0] filt_reg;
	logic [STRAP_W-1:0] filt_next;
	// Captured straps and capture sequencer.
	logic [STRAP_W-1:0] cap_reg;
	rscl_state_e state_reg;
	rscl_state_e state_next;
	logic capture;
	// Registers reachable over the bus.
	logic [15:0] ctrl_reg;
	logic [15:0] ctrl_next;
	logic [15:0] adv_reg;
	logic [15:0] adv_next;
	logic [15:0] adv_strap;
	logic changed_reg;
	// Bus decode.
	logic bus_req;
	logic bus_wr;
	logic hit_ctrl;
	logic hit_adv;
	logic hit_strap;
	logic hit_stat;
	logic [31:0] rd_mux;
	logic [31:0] dat_reg;
	logic ack_reg;
	// Output flops.
	logic [4:0] addr_reg;
	logic [2:0] mode_reg;
	logic rsvd_reg;
	logic iso_reg;
	logic bcoff_reg;
	logic wake_en_reg;
	logic gtest_reg;
	logic valid_reg;
	logic match_reg;
	logic bcast_reg;
	logic wake_reg;
	logic own_hit;
	logic zero_bcast;

	assign strap_pins = {gate_test_strap_n_i, wake_output_enable_strap_i,
		broadcast_off_strap_i, duplex_strap_i, speed_strap_i,
		autoneg_enable_strap_i, isolate_strap_i, if_mode_strap_i,
		mgmt_addr_strap_bit2_i, mgmt_addr_strap_bit1_i,
		mgmt_addr_strap_bit0_i};

	// A bit of the filter moves only once stages two and three agree.
	assign filt_next = (sync2_reg & ~(sync2_reg ^ sync3_reg)) |
		(filt_reg & (sync2_reg ^ sync3_reg));

	// The pin path runs free, so it has settled by the time reset lifts.
	// Reset must be held four edges with stable straps for that.
	always_ff @(posedge sys_clk_i) begin
		sync1_reg <= strap_pins;
		sync2_reg <= sync1_reg;
		sync3_reg <= sync2_reg;
		filt_reg <= filt_next;
	end

	// Capture happens once, on the first edge with reset low.
	assign capture = (state_reg == ST_WAIT) && !reset_i;

	// Sequencer next state. A corrupted code settles in the holding state,
	// so an upset can never cause a late capture after reset has lifted.
	always_comb begin
		case (state_reg)
			ST_WAIT: begin
				state_next = capture ? ST_HELD : ST_WAIT;
			end
			ST_HELD: begin
				state_next = ST_HELD;
			end
			default: begin
				state_next = ST_HELD;
			end
		endcase
	end

	// Sequencer and captured straps; nothing reloads them but reset.
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state_reg <= ST_WAIT;
			cap_reg <= STRAP_DEFAULT;
		end else begin
			state_reg <= state_next;
			if (capture) begin
				cap_reg <= filt_reg;
			end
		end
	end

	// Pin changes after capture are flagged but never applied.
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			changed_reg <= 1'b0;
		end else if (state_reg == ST_HELD && filt_reg != cap_reg) begin
			changed_reg <= 1'b1;
		end
	end

	// Bus decode; the upper address bits must be zero for a hit.
	assign bus_req = wb_cyc_i && wb_stb_i;
	assign bus_wr = bus_req && wb_we_i && ack_reg;
	assign hit_ctrl = (wb_adr_i == OFF_CTRL);
	assign hit_adv = (wb_adr_i == OFF_ADV);
	assign hit_strap = (wb_adr_i == OFF_STRAP);
	assign hit_stat = (wb_adr_i == OFF_STAT);

	// Advertisement as the speed strap leaves it.
	assign adv_strap = filt_reg[SB_SPD] ? ADV_ALL :
		(ADV_ALL & ~ADV_100_MASK);

	// The release edge wins over a bus write in the same cycle.
	always_comb begin
		ctrl_next = ctrl_reg;
		adv_next = adv_reg;
		if (capture) begin
			ctrl_next = 16'h0000;
			ctrl_next[CB_SPD] = filt_reg[SB_SPD];
			ctrl_next[CB_AN] = filt_reg[SB_AN];
			ctrl_next[CB_DUP] = filt_reg[SB_DUP];
			adv_next = adv_strap;
		end else if (bus_wr && hit_ctrl) begin
			ctrl_next = merge16(ctrl_reg, wb_dat_i, wb_sel_i);
		end else if (bus_wr && hit_adv) begin
			adv_next = merge16(adv_reg, wb_dat_i, wb_sel_i);
		end
	end

	// Control and advertisement registers.
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			ctrl_reg <= CTRL_RESET;
			adv_reg <= ADV_ALL;
		end else begin
			ctrl_reg <= ctrl_next;
			adv_reg <= adv_next;
		end
	end

	// Read mux; unmapped offsets read zero and writes there are dropped.
	assign rd_mux = hit_ctrl ? {16'h0000, ctrl_reg} :
		hit_adv ? {16'h0000, adv_reg} :
		hit_strap ? {19'h0_0000, cap_reg} :
		hit_stat ? {29'h0000_0000, rsvd_reg, changed_reg, valid_reg} :
		32'h0000_0000;

	// One wait state: ack rises the edge after the request and drops next.
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_req && !ack_reg;
			if (bus_req && !ack_reg) begin
				dat_reg <= rd_mux;
			end
		end
	end

	// Address match against the captured address.
	assign own_hit = (mgmt_req_addr_i == strap_addr(cap_reg));
	assign zero_bcast = (mgmt_req_addr_i == ADDR_ZERO) && !cap_reg[SB_BCOFF];

	// Applied configuration, all from flops.
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			addr_reg <= ADDR_DEFAULT;
			mode_reg <= MODE_MII;
			rsvd_reg <= 1'b0;
			iso_reg <= 1'b0;
			bcoff_reg <= 1'b0;
			wake_en_reg <= 1'b0;
			gtest_reg <= 1'b0;
			valid_reg <= 1'b0;
			match_reg <= 1'b0;
			bcast_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			addr_reg <= strap_addr(cap_reg);
			mode_reg <= cap_reg[SB_MODE0 +: 3];
			rsvd_reg <= (cap_reg[SB_MODE0 +: 3] != MODE_MII) &&
				(cap_reg[SB_MODE0 +: 3] != MODE_B2B);
			iso_reg <= cap_reg[SB_ISO];
			bcoff_reg <= cap_reg[SB_BCOFF];
			wake_en_reg <= cap_reg[SB_WAKE];
			gtest_reg <= !cap_reg[SB_GTEST_N];
			valid_reg <= (state_reg == ST_HELD);
			// Address zero is own only with broadcast off set high.
			match_reg <= valid_reg && (zero_bcast ||
				(own_hit && (mgmt_req_addr_i != ADDR_ZERO ||
				cap_reg[SB_BCOFF])));
			bcast_reg <= valid_reg && zero_bcast;
			wake_reg <= wake_req_i && cap_reg[SB_WAKE];
		end
	end

	assign wb_dat_o = dat_reg;
	assign wb_ack_o = ack_reg;
	assign mgmt_addr_o = addr_reg;
	assign if_mode_o = mode_reg;
	assign mode_reserved_o = rsvd_reg;
	assign isolate_o = iso_reg;
	assign autoneg_en_o = ctrl_reg[CB_AN];
	assign speed_100_o = ctrl_reg[CB_SPD];
	// High bit 8 means half duplex here, following the strap sense.
	assign half_duplex_o = ctrl_reg[CB_DUP];
	assign bcast_off_o = bcoff_reg;
	assign wake_out_en_o = wake_en_reg;
	assign gate_test_en_o = gtest_reg;
	assign config_valid_o = valid_reg;
	assign addr_match_o = match_reg;
	assign addr_bcast_o = bcast_reg;
	assign wake_event_output_o = wake_reg;

	// Checks, sampled on the system clock outside reset.
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	addr_upper_a: assert property (mgmt_addr_o[4:3] == 2'h0)
		else $error("upper address bits not zero");
	addr_capture_a: assert property (capture |=> ##1
		mgmt_addr_o[2:0] == $past(filt_reg[2:0], 2))
		else $error("address not taken from straps");
	strap_hold_a: assert property (state_reg == ST_HELD |=>
		$stable(cap_reg))
		else $error("captured straps changed");
	ctrl_load_a: assert property (capture |=>
		ctrl_reg[CB_SPD] == $past(filt_reg[SB_SPD]) &&
		ctrl_reg[CB_DUP] == $past(filt_reg[SB_DUP]) &&
		ctrl_reg[CB_AN] == $past(filt_reg[SB_AN]))
		else $error("control bits not loaded at release");
	adv_speed_a: assert property (capture && !filt_reg[SB_SPD] |=>
		(adv_reg & ADV_100_MASK) == 16'h0000)
		else $error("100 Mbps advertised with 10 Mbps strap");
	zero_unique_a: assert property (valid_reg &&
		mgmt_req_addr_i == ADDR_ZERO && cap_reg[SB_BCOFF] &&
		cap_reg[2:0] != 3'h0 |=> !addr_match_o)
		else $error("address zero matched while unique");
	zero_bcast_a: assert property (valid_reg &&
		mgmt_req_addr_i == ADDR_ZERO && !cap_reg[SB_BCOFF] |=>
		addr_match_o && addr_bcast_o)
		else $error("broadcast address zero not answered");
	mode_rsvd_a: assert property (state_reg == ST_HELD &&
		cap_reg[SB_MODE0 +: 3] == MODE_B2B |=> !mode_reserved_o)
		else $error("back-to-back mode flagged reserved");
	wake_gate_a: assert property (!cap_reg[SB_WAKE] |=>
		!wake_event_output_o)
		else $error("wake output with enable strap low");
	gate_test_a: assert property (state_reg == ST_HELD |=>
		gate_test_en_o == !$past(cap_reg[SB_GTEST_N]))
		else $error("gate test mode sense wrong");
	bus_ack_a: assert property (bus_req && !ack_reg |=> ack_reg ##1
		!ack_reg)
		else $error("ack not one wait state and one cycle");

	capture_c: cover property (capture);
	bcast_c: cover property (addr_bcast_o);
	write_c: cover property (bus_wr && hit_ctrl);
	rsvd_c: cover property (mode_reserved_o);
endmodule // rscl_top

// [verilog/rscl_pkg.sv]
package rscl_pkg;
	// Bus geometry.
	localparam int WB_AW = 8;
	localparam int WB_DW = 32;
	localparam int WB_SW = 4;
	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ADV = 8'h04;
	localparam logic [7:0] OFF_STRAP = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0C;
	// Captured strap vector layout.
	localparam int STRAP_W = 13;
	localparam int SB_ADDR0 = 0;
	localparam int SB_MODE0 = 3;
	localparam int SB_ISO = 6;
	localparam int SB_AN = 7;
	localparam int SB_SPD = 8;
	localparam int SB_DUP = 9;
	localparam int SB_BCOFF = 10;
	localparam int SB_WAKE = 11;
	localparam int SB_GTEST_N = 12;
	// Levels the internal pulls give when no jumper is fitted.
	localparam logic [12:0] STRAP_DEFAULT = 13'h1381;
	// Control register bit positions and reset value.
	localparam int CB_DUP = 8;
	localparam int CB_AN = 12;
	localparam int CB_SPD = 13;
	localparam logic [15:0] CTRL_RESET = 16'h3100;
	// Advertisement value with every speed, and the 100 Mbps bits.
	localparam logic [15:0] ADV_ALL = 16'h01E1;
	localparam logic [15:0] ADV_100_MASK = 16'h0180;
	// Management address: fixed upper bits and default.
	localparam logic [1:0] ADDR_UPPER = 2'h0;
	localparam logic [4:0] ADDR_DEFAULT = 5'h01;
	localparam logic [4:0] ADDR_ZERO = 5'h00;
	// Interface mode patterns.
	localparam logic [2:0] MODE_MII = 3'h0;
	localparam logic [2:0] MODE_B2B = 3'h6;
	// Status register bit positions.
	localparam int STB_VALID = 0;
	localparam int STB_CHANGED = 1;
	localparam int STB_RSVD = 2;
	// Capture sequencer states, one-hot.
	typedef enum logic [1:0] {
		ST_WAIT = 2'b01,
		ST_HELD = 2'b10
	} rscl_state_e;
endpackage

// [verif/rscl_strap_board.sv]
`timescale 1ns/1ps
// Board side of the strap pins. The internal pulls give the default levels,
// and every fitted jumper flips its pin to the opposite level.
module rscl_strap_board (
	input wire logic [rscl_pkg::STRAP_W-1:0] jumper_i,
	output logic [rscl_pkg::STRAP_W-1:0] strap_o
);
	import rscl_pkg::*;
	// With no jumper fitted the pins rest at the pull levels.
	assign strap_o = STRAP_DEFAULT ^ jumper_i;
endmodule // rscl_strap_board

// [verif/tb_rscl_top.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_rscl_top;
	import rscl_pkg::*;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [12:0] jumper = 13'h0000; // Fitted jumpers, one bit per pin.
	logic [12:0] strap;
	logic [12:0] j;
	logic [4:0] req_addr = 5'h00;
	logic wake_req = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic [31:0] exp_q[$]; // Expected read data, oldest first.
	logic [31:0] dat_o;
	logic ack, m_rsvd, iso, an, spd, half, bco, wen, gte, valid, match;
	logic bcast, wake_out;
	logic [4:0] m_addr;
	logic [2:0] mode;
	int failures = 0;
	int checked = 0;
	rscl_strap_board i_board (.jumper_i(jumper), .strap_o(strap));
	rscl_top i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.mgmt_addr_strap_bit0_i(strap[0]), .mgmt_addr_strap_bit1_i(strap[1]),
		.mgmt_addr_strap_bit2_i(strap[2]), .if_mode_strap_i(strap[5:3]),
		.isolate_strap_i(strap[6]), .autoneg_enable_strap_i(strap[7]),
		.speed_strap_i(strap[8]), .duplex_strap_i(strap[9]),
		.broadcast_off_strap_i(strap[10]),
		.wake_output_enable_strap_i(strap[11]),
		.gate_test_strap_n_i(strap[12]), .mgmt_req_addr_i(req_addr),
		.wake_req_i(wake_req), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .mgmt_addr_o(m_addr), .if_mode_o(mode),
		.mode_reserved_o(m_rsvd), .isolate_o(iso), .autoneg_en_o(an),
		.speed_100_o(spd), .half_duplex_o(half), .bcast_off_o(bco),
		.wake_out_en_o(wen), .gate_test_en_o(gte), .config_valid_o(valid),
		.addr_match_o(match), .addr_bcast_o(bcast),
		.wake_event_output_o(wake_out));
	// Free-running 20 MHz clock.
	initial begin
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	// Prints the verdict and stops; every path out of the run ends here.
	task automatic wrap_up();
		if (failures == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// One classic cycle, held until ack is sampled high at an edge.
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
		end
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// A read notes its expected word before the request goes out.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0000_0000, 4'hF);
	endtask
	// Fits jumpers, then pulses reset so the new levels get captured.
	task automatic boot(input logic [12:0] jp);
		@(posedge sys_clk_i);
		jumper <= jp;
		reset_i <= 1'b1;
		repeat (6) @(posedge sys_clk_i);
		`CHK("rst valid", 1'b0, valid)
		`CHK("rst addr", ADDR_DEFAULT, m_addr)
		reset_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
	endtask
	// Compares every applied setting with what the pin levels imply.
	task automatic check_cfg(input logic [12:0] s, input logic chg);
		logic rs;
		rs = !(s[5:3] == MODE_MII || s[5:3] == MODE_B2B);
		`CHK("addr", {ADDR_UPPER, s[2:0]}, m_addr)
		`CHK("mode", s[5:3], mode)
		`CHK("reserved", rs, m_rsvd)
		`CHK("isolate", s[SB_ISO], iso)
		`CHK("speed", s[SB_SPD], spd)
		`CHK("half", s[SB_DUP], half)
		`CHK("autoneg", s[SB_AN], an)
		`CHK("bcoff", s[SB_BCOFF], bco)
		`CHK("wake en", s[SB_WAKE], wen)
		`CHK("gate", ~s[SB_GTEST_N], gte)
		`CHK("valid", 1'b1, valid)
		rd(OFF_CTRL, {18'h0, s[SB_SPD], s[SB_AN], 3'h0, s[SB_DUP], 8'h0});
		rd(OFF_ADV, {16'h0, s[SB_SPD] ? ADV_ALL : ADV_ALL & ~ADV_100_MASK});
		rd(OFF_STRAP, {19'h0, s});
		rd(OFF_STAT, {29'h0, rs, chg, 1'b1});
		// Probe address zero, then the captured address.
		req_addr <= ADDR_ZERO;
		wake_req <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		`CHK("match0", s[SB_BCOFF] ? s[2:0] == 3'h0 : 1'b1, match)
		`CHK("bcast0", ~s[SB_BCOFF], bcast)
		`CHK("wake out", s[SB_WAKE], wake_out)
		req_addr <= {ADDR_UPPER, s[2:0]};
		wake_req <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		`CHK("match", 1'b1, match)
	endtask
	// Takes the oldest note whenever read data comes back.
	always @(posedge sys_clk_i) begin
		if (ack === 1'b1 && we === 1'b0) begin
			rdat = exp_q.pop_front();
			`CHK("read", rdat, dat_o)
		end
	end
	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (5000) @(posedge sys_clk_i);
		failures++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'hadea));
		boot(13'h0000);
		`CHK("default", ADDR_DEFAULT, m_addr)
		rd(OFF_CTRL, {16'h0, CTRL_RESET});
		check_cfg(STRAP_DEFAULT, 1'b0);
		// Every mode pattern with random other pins; address zero first.
		for (int i = 0; i < 8; i++) begin
			j = 13'($urandom());
			j[5:3] = 3'(i);
			if (i < 2) begin
				j[2:0] = 3'h1;
				j[SB_BCOFF] = i[0];
			end else if (i == 2) begin
				// Unique address zero while the own address is not zero.
				j[2:0] = 3'h0;
				j[SB_BCOFF] = 1'b1;
			end
			boot(j);
			check_cfg(STRAP_DEFAULT ^ j, 1'b0);
		end
		// Pins moved after capture set the changed flag and change no setting until the next reset.
		@(posedge sys_clk_i);
		jumper <= ~j;
		repeat (4) @(posedge sys_clk_i);
		check_cfg(STRAP_DEFAULT ^ j, 1'b1);
		boot(~j);
		check_cfg(STRAP_DEFAULT ^ ~j, 1'b0);
		// Rewrites of the loaded register; lanes and read-only places.
		wb(1'b1, OFF_CTRL, 32'h0000_0000, 4'hF);
		// The write lands at the ack edge; look one edge later.
		@(posedge sys_clk_i);
		`CHK("an wr", 1'b0, an)
		`CHK("spd wr", 1'b0, spd)
		wb(1'b1, OFF_CTRL, 32'hFFFF_3100, 4'h2);
		wb(1'b1, OFF_CTRL, 32'h0000_0000, 4'h1);
		rd(OFF_CTRL, {16'h0, CTRL_RESET});
		wb(1'b1, OFF_STRAP, 32'h0000_0000, 4'hF);
		rd(OFF_STRAP, {19'h0, STRAP_DEFAULT ^ ~j});
		wb(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF);
		rd(8'h10, 32'h0000_0000);
		repeat (3) @(posedge sys_clk_i);
		`CHK("pending", 0, exp_q.size())
		wrap_up();
	end
endmodule // tb_rscl_top
